// ### rtl/sers_consts.vh
// Purpose: shared constants for the status event register sets
// Assumes: included by bare name from rtl sources
// Notes:   register selects are local numbering of the command decoder
`ifndef SERS_CONSTS_VH
`define SERS_CONSTS_VH

// register select codes (4 bits)
`define SERS_SEL_STD_EVENT   4'h0
`define SERS_SEL_OPER_EVENT  4'h1
`define SERS_SEL_MEAS_EVENT  4'h2
`define SERS_SEL_QUES_EVENT  4'h3
`define SERS_SEL_OPER_COND   4'h4
`define SERS_SEL_MEAS_COND   4'h5
`define SERS_SEL_QUES_COND   4'h6
`define SERS_SEL_STD_MASK    4'h7
`define SERS_SEL_OPER_MASK   4'h8
`define SERS_SEL_MEAS_MASK   4'h9
`define SERS_SEL_QUES_MASK   4'ha

// standard event bit positions
`define SERS_STD_OPC_DONE    0
`define SERS_STD_EMPTY_READ  2
`define SERS_STD_INT_FAULT   3
`define SERS_STD_RUN_FAULT   4
`define SERS_STD_CMD_ERROR   5
`define SERS_STD_LOCAL_KEY   6
`define SERS_STD_PWR_CYCLED  7

// operation bit positions
`define SERS_OP_CUR_LIMIT    3
`define SERS_OP_TRIP_OFF     4
`define SERS_OP_OVL_SHUT     6

// measurement bit positions
`define SERS_MS_OVER_RANGE   3
`define SERS_MS_PULSE_TMO    4
`define SERS_MS_READ_READY   5
`define SERS_MS_AVG_DONE     9

// questionable bit position
`define SERS_QS_CAL_BAD      8

// implemented bit masks
`define SERS_STD_IMPL        8'hfd
`define SERS_OP_IMPL         16'h0058
`define SERS_MS_IMPL         16'h0238
`define SERS_QS_IMPL         16'h0100

// reset values
`define SERS_RST8            8'h00
`define SERS_RST16           16'h0000

`endif

// ### rtl/sers_status_sets.v
// Purpose: four status register sets with latching events, masks, summaries
// Assumes: command decoder delivers one-cycle read/write strobes on sys_clk
// Notes:   reads return data one cycle after the strobe
//
// Notes on behaviour
// - four sets: standard, operation, measurement, questionable
// - standard B0 on operations-done with nothing pending
// - standard B2 on read of empty output queue
// - standard B3 on internal fault
// - standard B4 on command execution fault
// - standard B5 on any command error
// - standard B6 on local key press
// - standard B7 after power cycle
// - operation B3 follows current limit condition
// - operation B4 on trip off, cleared on output-on
// - operation B6 on overload or overheat shutdown
// - measurement B3 on reading over range
// - measurement B5 each reading ready
// - measurement B9 when average count done
// - questionable B8 bad calibration, cleared by calibration
// - live condition registers for three sets only
// - measurement condition B4 high until pulse seen
// - event bits latch until register reset
// - reading an event register clears it
// - reset and clear-all clear events, preset not
// - summary is OR of events AND masks
// - reset and preset clear masks, clear-all not
// - summaries drive status byte bits unlatched
//
// overview of the data path:
// - standard events arrive as one-cycle pulses and are ORed into
//   an 8-bit latch; there is no condition register for this set
// - operation, measurement and questionable conditions are live
//   levels; a rising edge of a condition sets the event bit
// - each latch is cleared by a read of its own select or by the
//   clear-all command; an event in that same cycle still lands
// - masks are written by the command decoder; only implemented
//   bit positions are stored, so reads never show dead bits
// - the four summaries are pure logic on latches and masks, so
//   they fall in the cycle after the read that empties a latch
// - one clock enable freezes every flip-flop, the edge detectors
//   included, so a frozen cycle neither loses nor invents an edge
// limitations:
// - a condition that rises while the clock enable is low is seen
//   when the enable returns, not at the moment it happened
// - read data is registered, so a read answer is one cycle late
// - the status byte carries only the four set summaries here; the
//   queue and service request bits are owned by other logic
`timescale 1ns/10ps
`default_nettype none
`include "sers_consts.vh"

module sers_status_sets (
    // clock and control
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        clkEn,
    // register access from the command decoder
    input  wire        regRead,
    input  wire        regWrite,
    input  wire [3:0]  regSel,
    input  wire [15:0] regWrData,
    output reg  [15:0] regRdData,
    output reg         regRdValid,
    // commands
    input  wire        operationsDoneCmd,
    input  wire        opsPending,
    input  wire        clearAllStatusCmd,
    input  wire        statusPresetCmd,
    // standard events (one-cycle pulses)
    input  wire        emptyReadError,
    input  wire        internalFault,
    input  wire        runFault,
    input  wire        commandError,
    input  wire        localKeyRequest,
    input  wire        powerCycled,
    // instrument conditions (levels, same clock)
    input  wire        currentLimit,
    input  wire        limitTripOff,
    input  wire        outputOn,
    input  wire        overloadShutdown,
    input  wire        readingOverRange,
    input  wire        pulseDetected,
    input  wire        readingReady,
    input  wire        averageCountDone,
    input  wire        calBadAtPowerUp,
    input  wire        calSuccess,
    // summaries to status byte
    output wire        measSummary,
    output wire        questionableSummary,
    output wire        stdEventSummary,
    output wire        operationSummary,
    output wire [7:0]  statusByteSummaries
);

    ////////////////////////////////////////////////////////////////////////////
    // state: one latch and one mask per set, four sets in all
    // condition registers are not stored; they are read straight from
    // the live inputs and the trip and calibration holds, which keeps them truly real-time
    reg  [7:0]  stdEvent_reg;      // standard event latch
    reg  [15:0] operEvent_reg;     // operation event latch
    reg  [15:0] measEvent_reg;     // measurement event latch
    reg  [15:0] quesEvent_reg;     // questionable event latch
    reg  [7:0]  stdMask_reg;       // standard event mask
    reg  [15:0] operMask_reg;      // operation mask
    reg  [15:0] measMask_reg;      // measurement mask
    reg  [15:0] quesMask_reg;      // questionable mask
    reg  [15:0] operCondPrev_reg;  // previous condition for edge detection
    reg  [15:0] measCondPrev_reg;
    reg  [15:0] quesCondPrev_reg;
    reg         tripHold_reg;      // trip off held until output back on
    reg         calBad_reg;        // bad calibration held until calibrated

    reg  [7:0]  stdSet;            // standard event set pulses
    reg  [15:0] operCond;          // live conditions
    reg  [15:0] measCond;
    reg  [15:0] quesCond;
    wire [15:0] operRise;
    wire [15:0] measRise;
    wire [15:0] quesRise;
    wire        rdStd;
    wire        rdOper;
    wire        rdMeas;
    wire        rdQues;
    wire [15:0] stdNext;           // standard latch next value, upper half unused

    ////////////////////////////////////////////////////////////////////////////
    // next latch value: set wins over read clear
    // shared by all four sets; the standard set pads to 16 bits and
    // keeps only the low byte of the result
    // giving the set priority means a read can never swallow an event
    // that arrives in the very cycle of the read
    function [15:0] sersLatch;
        input [15:0] cur;
        input [15:0] setBits;
        input        clr;
        begin
            sersLatch = (clr ? 16'h0000 : cur) | setBits;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // standard event sources
    always @* begin
        stdSet = 8'h00;
        stdSet[`SERS_STD_OPC_DONE]   = operationsDoneCmd & ~opsPending;
        stdSet[`SERS_STD_EMPTY_READ] = emptyReadError;
        stdSet[`SERS_STD_INT_FAULT]  = internalFault;
        stdSet[`SERS_STD_RUN_FAULT]  = runFault;
        stdSet[`SERS_STD_CMD_ERROR]  = commandError;
        stdSet[`SERS_STD_LOCAL_KEY]  = localKeyRequest;
        stdSet[`SERS_STD_PWR_CYCLED] = powerCycled;
    end

    // live conditions, no register of their own; standard set has none
    always @* begin
        operCond = 16'h0000;
        operCond[`SERS_OP_CUR_LIMIT] = currentLimit;
        operCond[`SERS_OP_TRIP_OFF]  = tripHold_reg;
        operCond[`SERS_OP_OVL_SHUT]  = overloadShutdown;
        measCond = 16'h0000;
        measCond[`SERS_MS_OVER_RANGE] = readingOverRange;
        measCond[`SERS_MS_PULSE_TMO]  = ~pulseDetected;
        measCond[`SERS_MS_READ_READY] = readingReady;
        measCond[`SERS_MS_AVG_DONE]   = averageCountDone;
        quesCond = 16'h0000;
        quesCond[`SERS_QS_CAL_BAD] = calBad_reg;
    end

    // rising edges latch events; a held level does not relatch after read
    assign operRise = operCond & ~operCondPrev_reg;
    assign measRise = measCond & ~measCondPrev_reg;
    assign quesRise = quesCond & ~quesCondPrev_reg;

    // read strobes that clear event latches
    assign rdStd  = regRead & (regSel == `SERS_SEL_STD_EVENT);
    assign rdOper = regRead & (regSel == `SERS_SEL_OPER_EVENT);
    assign rdMeas = regRead & (regSel == `SERS_SEL_MEAS_EVENT);
    assign rdQues = regRead & (regSel == `SERS_SEL_QUES_EVENT);

    ////////////////////////////////////////////////////////////////////////////
    // held conditions: trip until output on, calibration flag
    // these two are sticky levels, not events: they feed condition
    // bits, and the event latch only records their rising edge
    // a new trip or a new bad-calibration report beats a clear that
    // arrives in the same cycle, so the fault is never hidden
    always @(posedge sys_clk) begin
        if (rst) begin
            tripHold_reg <= 1'b0;
            calBad_reg   <= 1'b0;
        end else if (clkEn) begin
            // clearing by output-on wins only when no new trip arrives
            if (limitTripOff) begin
                tripHold_reg <= 1'b1;
            end else if (outputOn) begin
                tripHold_reg <= 1'b0;
            end
            if (calBadAtPowerUp) begin
                calBad_reg <= 1'b1;
            end else if (calSuccess) begin
                calBad_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event latches
    // edge detectors reset to zero, so a condition already high at
    // release of reset is taken as a fresh edge one cycle later;
    // that is intended, the user sees conditions present at power-up
    assign stdNext = sersLatch({8'h00, stdEvent_reg}, {8'h00, stdSet},
                               rdStd | clearAllStatusCmd);
    always @(posedge sys_clk) begin
        if (rst) begin
            stdEvent_reg     <= `SERS_RST8;
            operEvent_reg    <= `SERS_RST16;
            measEvent_reg    <= `SERS_RST16;
            quesEvent_reg    <= `SERS_RST16;
            operCondPrev_reg <= `SERS_RST16;
            measCondPrev_reg <= `SERS_RST16;
            quesCondPrev_reg <= `SERS_RST16;
        end else if (clkEn) begin
            operCondPrev_reg <= operCond;
            measCondPrev_reg <= measCond;
            quesCondPrev_reg <= quesCond;
            // clear-all acts like a read on every set; new events still land
            // only the low byte exists in the standard set
            stdEvent_reg  <= stdNext[7:0];
            operEvent_reg <= sersLatch(operEvent_reg, operRise,
                                       rdOper | clearAllStatusCmd);
            measEvent_reg <= sersLatch(measEvent_reg, measRise,
                                       rdMeas | clearAllStatusCmd);
            quesEvent_reg <= sersLatch(quesEvent_reg, quesRise,
                                       rdQues | clearAllStatusCmd);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // enable masks: only implemented bits are stored
    // preset beats a write in the same cycle; clear-all leaves masks
    // alone, so a user can clear events without reprogramming masks
    // dropping dead bits here means the summary cannot be raised by
    // a mask bit whose event can never occur
    always @(posedge sys_clk) begin
        if (rst) begin
            stdMask_reg  <= `SERS_RST8;
            operMask_reg <= `SERS_RST16;
            measMask_reg <= `SERS_RST16;
            quesMask_reg <= `SERS_RST16;
        end else if (clkEn) begin
            if (statusPresetCmd) begin
                stdMask_reg  <= `SERS_RST8;
                operMask_reg <= `SERS_RST16;
                measMask_reg <= `SERS_RST16;
                quesMask_reg <= `SERS_RST16;
            end else if (regWrite) begin
                // zero written disables every bit of the chosen mask
                if (regSel == `SERS_SEL_STD_MASK) begin
                    stdMask_reg <= regWrData[7:0] & `SERS_STD_IMPL;
                end else if (regSel == `SERS_SEL_OPER_MASK) begin
                    operMask_reg <= regWrData & `SERS_OP_IMPL;
                end else if (regSel == `SERS_SEL_MEAS_MASK) begin
                    measMask_reg <= regWrData & `SERS_MS_IMPL;
                end else if (regSel == `SERS_SEL_QUES_MASK) begin
                    quesMask_reg <= regWrData & `SERS_QS_IMPL;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: registered data, unknown selects read zero
    // registering the answer costs one cycle of latency but gives the
    // decoder a clean, glitch-free word to format as text
    // read data holds until the next accepted read; valid is a pulse
    always @(posedge sys_clk) begin
        if (rst) begin
            regRdData  <= 16'h0000;
            regRdValid <= 1'b0;
        end else if (clkEn) begin
            regRdValid <= regRead;
            if (regRead) begin
                // value returned is the latch before this read clears it
                if (regSel == `SERS_SEL_STD_EVENT) begin
                    regRdData <= {8'h00, stdEvent_reg};
                end else if (regSel == `SERS_SEL_OPER_EVENT) begin
                    regRdData <= operEvent_reg;
                end else if (regSel == `SERS_SEL_MEAS_EVENT) begin
                    regRdData <= measEvent_reg;
                end else if (regSel == `SERS_SEL_QUES_EVENT) begin
                    regRdData <= quesEvent_reg;
                end else if (regSel == `SERS_SEL_OPER_COND) begin
                    regRdData <= operCond;
                end else if (regSel == `SERS_SEL_MEAS_COND) begin
                    regRdData <= measCond;
                end else if (regSel == `SERS_SEL_QUES_COND) begin
                    regRdData <= quesCond;
                end else if (regSel == `SERS_SEL_STD_MASK) begin
                    regRdData <= {8'h00, stdMask_reg};
                end else if (regSel == `SERS_SEL_OPER_MASK) begin
                    regRdData <= operMask_reg;
                end else if (regSel == `SERS_SEL_MEAS_MASK) begin
                    regRdData <= measMask_reg;
                end else if (regSel == `SERS_SEL_QUES_MASK) begin
                    regRdData <= quesMask_reg;
                end else begin
                    regRdData <= 16'h0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // summaries: combinational from latches, so a read drops them at once
    // no flip-flop here on purpose: the status byte bits must follow
    // the summaries without latching of their own
    // a user who wants an edge to signal on must watch the byte
    assign stdEventSummary     = |(stdEvent_reg & stdMask_reg);
    assign operationSummary    = |(operEvent_reg & operMask_reg);
    assign measSummary         = |(measEvent_reg & measMask_reg);
    assign questionableSummary = |(quesEvent_reg & quesMask_reg);
    // status byte positions B0, B3, B5, B7; other bits belong elsewhere
    assign statusByteSummaries = {operationSummary, 1'b0, stdEventSummary, 1'b0,
                                  questionableSummary, 2'b00, measSummary};

endmodule
`default_nettype wire

// ### tb/sers_ctrl_model.sv
// Purpose: remote controller model issuing register requests
// Assumes: issue is called once per cycle just after the rising edge
// Notes:   idle cycles scramble select and data so stale values never pass
`timescale 1ns/10ps
`default_nettype none
module sers_ctrl_model (
    // request strobes
    output var logic        regRead,
    output var logic        regWrite,
    // select and write data
    output var logic [3:0]  regSel,
    output var logic [15:0] regWrData
);
    // quiet bus at time zero
    initial begin
        {regRead, regWrite, regSel, regWrData} = 22'h0;
    end
    // one-cycle request; a zero write is how a mask is switched off
    task automatic issue(input logic rd, input logic wr, input logic [3:0] s,
                         input logic [15:0] d);
        regRead = rd;
        regWrite = wr;
        regSel = (rd | wr) ? s : ~regSel;
        regWrData = wr ? d : ~regWrData;
    endtask
endmodule
`default_nettype wire

// ### tb/sers_status_sets_asserts.sv
// Purpose: port-level assertions for the status register sets
// Assumes: bound to sers_status_sets
// Notes:   summaries are also seen through the packed status byte
`timescale 1ns/10ps
`default_nettype none
module sers_status_sets_asserts (
    // clock and control
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        clkEn,
    // register access
    input wire logic        regRead,
    input wire logic        regWrite,
    input wire logic [3:0]  regSel,
    input wire logic [15:0] regRdData,
    input wire logic        regRdValid,
    // commands and conditions
    input wire logic        clearAllStatusCmd,
    input wire logic        statusPresetCmd,
    input wire logic        pulseDetected,
    // summaries
    input wire logic        measSummary,
    input wire logic        questionableSummary,
    input wire logic        stdEventSummary,
    input wire logic        operationSummary,
    input wire logic [7:0]  statusByteSummaries
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    property p_rd_answer;
        clkEn && regRead |=> regRdValid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_quiet;
        clkEn && !regRead |=> !regRdValid;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("stray read answer");
    property p_byte_map;
        statusByteSummaries == {operationSummary, 1'b0, stdEventSummary, 1'b0,
                                questionableSummary, 2'b00, measSummary};
    endproperty
    a_byte_map: assert property (p_byte_map) else $error("status byte packing");
    property p_preset;
        clkEn && statusPresetCmd |=> statusByteSummaries == 8'h00;
    endproperty
    a_preset: assert property (p_preset) else $error("summary after preset");
    property p_unmapped;
        clkEn && regRead && regSel > 4'ha |=> regRdData == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_op_mask;
        clkEn && regRead && regSel == 4'h8 |=> (regRdData & 16'hffa7) == 16'h0000;
    endproperty
    a_op_mask: assert property (p_op_mask) else $error("mask holds dead bits");
    property p_pulse_cond;
        clkEn && regRead && regSel == 4'h5 |=> regRdData[4] == !$past(pulseDetected);
    endproperty
    a_pulse_cond: assert property (p_pulse_cond) else $error("pulse condition bit");
    // only a read of its register, a clear, a preset or a mask write may drop it
    property p_std_hold;
        stdEventSummary && !(regRead && regSel == 4'h0) && !clearAllStatusCmd
            && !statusPresetCmd && !regWrite |=> stdEventSummary;
    endproperty
    a_std_hold: assert property (p_std_hold) else $error("summary dropped");
endmodule
bind sers_status_sets sers_status_sets_asserts i_chk (.sys_clk, .rst, .clkEn, .regRead,
    .regWrite, .regSel, .regRdData, .regRdValid, .clearAllStatusCmd, .statusPresetCmd,
    .pulseDetected, .measSummary, .questionableSummary, .stdEventSummary,
    .operationSummary, .statusByteSummaries);
`default_nettype wire

// ### tb/sers_status_sets_bench.sv
// Purpose: self-checking bench for the status register sets
// Assumes: rtl header on the include path
// Notes:   a shadow model tracks events, masks and holds each cycle
`timescale 1ns/10ps
`default_nettype none
`include "sers_consts.vh"
module sers_status_sets_bench;
    logic        sys_clk, rst, clkEn;
    logic [6:0]  stdP;            // {pwr, key, cmd, run, int, empty, opsDone}
    logic [12:0] lv;              // levels, holds and commands, see port map
    logic [12:0] nv;              // next lv, built before one assignment
    logic [15:0] ev [0:3];        // shadow events
    logic [15:0] mk [0:3];        // shadow masks
    logic [15:0] pc [0:3];        // previous conditions for edge detect
    logic [15:0] st, expRd;
    logic        trH, calH, expV;
    logic [3:0]  s4;
    logic [31:0] r;
    logic [1:0]  op, lastOp;
    int          err_count, comparisons, i, k;
    wire  [15:0] rdData, wrData;
    wire  [7:0]  sbs;
    wire  [3:0]  sel;
    wire         rdValid, rd, wr, measS, quesS, stdS, opS;
    sers_ctrl_model i_ctl (.regRead(rd), .regWrite(wr), .regSel(sel), .regWrData(wrData));
    sers_status_sets i_dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .regRead(rd),
        .regWrite(wr), .regSel(sel), .regWrData(wrData), .regRdData(rdData),
        .regRdValid(rdValid), .operationsDoneCmd(stdP[0]), .opsPending(lv[10]),
        .clearAllStatusCmd(lv[11]), .statusPresetCmd(lv[12]), .emptyReadError(stdP[1]),
        .internalFault(stdP[2]), .runFault(stdP[3]), .commandError(stdP[4]),
        .localKeyRequest(stdP[5]), .powerCycled(stdP[6]), .currentLimit(lv[0]),
        .limitTripOff(lv[1]), .outputOn(lv[2]), .overloadShutdown(lv[3]),
        .readingOverRange(lv[4]), .pulseDetected(lv[5]), .readingReady(lv[6]),
        .averageCountDone(lv[7]), .calBadAtPowerUp(lv[8]), .calSuccess(lv[9]),
        .measSummary(measS), .questionableSummary(quesS), .stdEventSummary(stdS),
        .operationSummary(opS), .statusByteSummaries(sbs));
    ////////////////////////////////////////////////////////////////////////
    // live condition of set k as seen just before the edge
    function automatic logic [15:0] cnd(input int k);
        case (k)
            1: cnd = {9'h0, lv[3], 1'b0, trH, lv[0], 3'h0};
            2: cnd = {6'h0, lv[7], 3'h0, lv[6], ~lv[5], lv[4], 3'h0};
            3: cnd = {7'h0, calH, 8'h0};
            default: cnd = 16'h0000;
        endcase
    endfunction
    function automatic logic [15:0] impl(input int k);
        case (k)
            0: impl = {8'h00, `SERS_STD_IMPL};
            1: impl = `SERS_OP_IMPL;
            2: impl = `SERS_MS_IMPL;
            default: impl = `SERS_QS_IMPL;
        endcase
    endfunction
    // read value by select; unmapped selects answer zero
    function automatic logic [15:0] rdv(input logic [3:0] s);
        if (s < 4'h4) rdv = ev[s[1:0]];
        else if (s < 4'h7) rdv = cnd(int'(s) - 3);
        else if (s < 4'hb) rdv = mk[s - 4'h7];
        else rdv = 16'h0000;
    endfunction
    // shadow update; a new event beats a clear in the same cycle
    always @(posedge sys_clk) begin
        if (rst) begin
            for (k = 0; k < 4; k++) {ev[k], mk[k], pc[k]} <= 48'h0;
            {trH, calH, expV, expRd} <= 19'h0;
        end else if (clkEn) begin
            expV <= rd;
            if (rd) expRd <= rdv(sel);
            for (k = 0; k < 4; k++) begin
                st = k == 0 ? {8'h0, stdP[6:1], 1'b0, stdP[0] & ~lv[10]} : cnd(k) & ~pc[k];
                pc[k] <= cnd(k);
                ev[k] <= ((lv[11] || (rd && sel == k)) ? 16'h0 : ev[k]) | st;
                if (lv[12]) mk[k] <= 16'h0000;
                else if (wr && sel == k + 7) mk[k] <= wrData & impl(k);
            end
            trH <= lv[1] | (trH & ~lv[2]);
            calH <= lv[8] | (calH & ~lv[9]);
        end
    end
    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_sum(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // outputs are settled at the falling edge
    always @(negedge sys_clk) begin
        if (!rst) begin
            for (k = 0; k < 4; k++) s4[k] = |(ev[k] & mk[k]);
            chk_sum(sbs, {s4[1], 1'b0, s4[0], 1'b0, s4[3], 2'b00, s4[2]});
            chk_sum({3'h0, rdValid, opS, stdS, quesS, measS}, {3'h0, expV, s4[1], s4[0], s4[3], s4[2]});
            if (expV === 1'b1) chk_data(rdData, expRd);
        end
    end
    task automatic step(input logic r0, input logic w0, input logic [3:0] s,
                        input logic [15:0] d, input logic [6:0] p);
        @(posedge sys_clk);
        #1;
        i_ctl.issue(r0, w0, s, d);
        stdP = p;
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // watchdog, well past the expected run length
    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        {rst, clkEn, stdP, lv, lastOp, err_count, comparisons} = {2'b11, 7'h0, 13'h0020, 66'h0};
        r = $urandom(32'h60ea);
        repeat (16) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        for (i = 0; i < 16; i++) step(1'b1, 1'b0, i[3:0], 16'h0, 7'h0);
        for (i = 7; i < 11; i++) begin
            step(1'b0, 1'b1, i[3:0], 16'hffff, 7'h0);
            step(1'b1, 1'b0, i[3:0], 16'h0, 7'h0);
        end
        step(1'b1, 1'b0, 4'h0, 16'h0, 7'h40);
        step(1'b1, 1'b0, 4'h0, 16'h0, 7'h0);
        // random traffic with a reset in mid-run
        for (i = 0; i < 3000; i++) begin
            r = $urandom;
            op = (r[1:0] == 2'b11) ? 2'b00 : r[1:0];
            step(op == 2'b01, op == 2'b10, op == 2'b10 ? 4'h7 + r[3:2] : r[7:4],
                 r[8] ? 16'h0 : 16'($urandom), 7'($urandom & $urandom & $urandom) & ~stdP);
            nv = lv ^ (13'($urandom & $urandom & $urandom) & 13'h00f9);
            r = $urandom;
            nv[2:1] = r[2:0] == 3'h0 ? {r[3], ~r[3]} : 2'b00;
            nv[9:8] = r[6:4] == 3'h0 ? {r[7], ~r[7]} : 2'b00;
            nv[12:10] = {r[18:14] == 5'h0, r[13:9] == 5'h0, r[8]};
            lv = nv;
            rst = i >= 1500 && i < 1503;
            clkEn = rst || !(r[21:19] == 3'h0 && lastOp == 2'b00);
            lastOp = op;
        end
        step(1'b0, 1'b0, 4'h0, 16'h0, 7'h0);
        repeat (3) @(posedge sys_clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
